// *** verilog/pbio_port.sv ***
// port b bidirectional i/o block with ahb-lite register slave
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pbio_port #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // ahb-lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // configuration strap
    input  wire logic               global_pulldown_disable,
    // pins
    input  wire logic [WIDTH-1:0]   port_b_pin_in,
    output pbio_pkg::pbio_pins_t    pins,
    // other modules
    input  wire pbio_pkg::pbio_alt_t alt,
    output pbio_pkg::pbio_fwd_t     fwd
);
    import pbio_pkg::*;

    typedef struct packed {
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        logic [7:0]  sync3;
        logic [7:0]  level;
        logic [7:0]  port_b_latch;
        logic [7:0]  port_b_direction;
        logic [7:0]  port_b_pulldown_inhibit;
        logic        strap_done;
        logic        global_pd_off;
        logic        wr_pend;
        logic [9:0]  wr_addr;
        logic [31:0] rdata;
        pbio_pins_t  pins;
        pbio_fwd_t   fwd;
    } pbio_state_t;

    pbio_state_t s_q;
    pbio_state_t s_d;

    logic [7:0] drv;
    logic [7:0] oe;
    logic [7:0] rd_port;
    logic       take;

    always_comb begin
        s_d  = s_q;
        take = hsel && hready && (htrans == PBIO_HTRANS_NONSEQ || htrans == PBIO_HTRANS_SEQ);
        // three stage sampling; a change counts when stage two and three agree
        s_d.sync1 = port_b_pin_in;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        for (int i = 0; i < 8; i++) begin
            if (s_q.sync2[i] == s_q.sync3[i]) begin
                s_d.level[i] = s_q.sync3[i];
            end
        end
        // strap caught once after reset release; fixed after that
        if (!s_q.strap_done) begin
            s_d.strap_done    = 1'b1;
            s_d.global_pd_off = global_pulldown_disable;
        end
        // write data phase
        if (s_q.wr_pend) begin
            case (s_q.wr_addr)
                PBIO_ADDR_LATCH: s_d.port_b_latch = hwdata[7:0];
                PBIO_ADDR_DIR: s_d.port_b_direction = hwdata[7:0];
                PBIO_ADDR_PDI: s_d.port_b_pulldown_inhibit = hwdata[7:0];
                default: ;
            endcase
        end
        s_d.wr_pend = take && hwrite;
        s_d.wr_addr = haddr[9:0];
        // pin drive: latch plus overrides on upper pins
        drv = s_q.port_b_latch;
        oe  = s_q.port_b_direction;
        drv[PBIO_CMP_BIT] = s_q.port_b_latch[PBIO_CMP_BIT] | alt.timer_compare_out
                          | (alt.comparator_one_en & alt.comparator_one_out);
        if (alt.serial_enable) begin
            drv[PBIO_SDO_BIT] = alt.serial_data_out;
            oe[PBIO_SDO_BIT]  = 1'b1;
            oe[PBIO_SDI_BIT]  = 1'b0;
            drv[PBIO_SCK_BIT] = alt.serial_clk_out;
            oe[PBIO_SCK_BIT]  = alt.serial_clk_oe;
        end
        for (int i = 0; i < 8; i++) begin
            // direction selects latch or pin level for reads
            rd_port[i] = s_q.port_b_direction[i] ? s_q.port_b_latch[i] : s_q.level[i];
            // a set direction bit kills the pulldown even when an override takes the driver
            s_d.pins.pulldown_en[i] = !s_q.global_pd_off && !oe[i] && !s_q.port_b_direction[i]
                                    && !s_q.port_b_pulldown_inhibit[i];
        end
        s_d.pins.out = drv;
        s_d.pins.oe  = oe;
        s_d.fwd.analog_level     = s_q.level[3:0];
        s_d.fwd.timer_capture_in = s_q.level[PBIO_CAP_BIT];
        s_d.fwd.serial_data_in   = s_q.level[PBIO_SDI_BIT];
        s_d.fwd.serial_clk_in    = s_q.level[PBIO_SCK_BIT];
        // read data for next data phase; inhibit reads back zero
        s_d.rdata = PBIO_RD_ZERO;
        if (take && !hwrite) begin
            case (haddr[9:0])
                PBIO_ADDR_LATCH: s_d.rdata = {24'h00_0000, rd_port};
                PBIO_ADDR_DIR: s_d.rdata = {24'h00_0000, s_q.port_b_direction};
                PBIO_ADDR_PDI: s_d.rdata = PBIO_RD_ZERO;
                default: s_d.rdata = PBIO_RD_ZERO;
            endcase
        end
    end

    // the latch is left out of the reset branch, so a reset keeps its contents
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q.sync1 <= 8'h00;
            s_q.sync2 <= 8'h00;
            s_q.sync3 <= 8'h00;
            s_q.level <= 8'h00;
            s_q.port_b_direction <= PBIO_DIR_RST;
            s_q.port_b_pulldown_inhibit <= PBIO_PDI_RST;
            s_q.strap_done <= 1'b0;
            s_q.global_pd_off <= 1'b0;
            s_q.wr_pend <= 1'b0;
            s_q.wr_addr <= 10'h000;
            s_q.rdata <= PBIO_RD_ZERO;
            s_q.pins <= '0;
            s_q.fwd <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata    = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign pins      = s_q.pins;
    assign fwd       = s_q.fwd;
endmodule

// *** verilog/pbio_pkg.sv ***
// package for the port b bidirectional i/o block: map, fields and carriers
package pbio_pkg;
    localparam int PBIO_WIDTH = 8;
    localparam logic [7:0] PBIO_IDX_LATCH = 8'h01;
    localparam logic [7:0] PBIO_IDX_DIR   = 8'h05;
    localparam logic [7:0] PBIO_IDX_PDI   = 8'h06;
    localparam logic [9:0] PBIO_ADDR_LATCH = {PBIO_IDX_LATCH, 2'b00};
    localparam logic [9:0] PBIO_ADDR_DIR   = {PBIO_IDX_DIR, 2'b00};
    localparam logic [9:0] PBIO_ADDR_PDI   = {PBIO_IDX_PDI, 2'b00};
    localparam logic [7:0]  PBIO_DIR_RST  = 8'h00;
    localparam logic [7:0]  PBIO_PDI_RST  = 8'h00;
    localparam logic [31:0] PBIO_RD_ZERO  = 32'h0000_0000;
    localparam logic [1:0]  PBIO_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0]  PBIO_HTRANS_SEQ    = 2'b11;
    localparam int PBIO_SCK_BIT = 7;
    localparam int PBIO_SDI_BIT = 6;
    localparam int PBIO_SDO_BIT = 5;
    localparam int PBIO_CMP_BIT = 4;
    localparam int PBIO_CAP_BIT = 3;

    // pins as seen from the block: drive value, enable and pulldown
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pulldown_en;
    } pbio_pins_t;

    // outputs of other modules that may take over pins 4-7
    typedef struct packed {
        logic timer_compare_out;
        logic comparator_one_out;
        logic comparator_one_en;
        logic serial_enable;
        logic serial_data_out;
        logic serial_clk_out;
        logic serial_clk_oe;
    } pbio_alt_t;

    // levels forwarded to attached modules
    typedef struct packed {
        logic [3:0] analog_level;
        logic       timer_capture_in;
        logic       serial_data_in;
        logic       serial_clk_in;
    } pbio_fwd_t;
endpackage

// *** bench/pbio_port_assertions.sv ***
// concurrent checks on the port b i/o block ports
`timescale 1ns/1ps
module pbio_port_assertions (
    // clock and reset
    input wire logic                 hclk,
    input wire logic                 hresetn,
    // bus
    input wire logic                 hsel,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [31:0]          hrdata,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    // strap and pins
    input wire logic                 global_pulldown_disable,
    input wire pbio_pkg::pbio_pins_t pins
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ready_high: assert property (hreadyout) else $error("wait state");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000) else $error("upper bits");
    a_idle_data_zero: assert property (!(hsel && htrans[1] && !hwrite) |=>
        hrdata == 32'h0000_0000) else $error("stale read data");
    a_oe_no_pull: assert property ((pins.oe & pins.pulldown_en) == 8'h00)
        else $error("pulldown on driven pin");
    a_strap_all_off: assert property (global_pulldown_disable |-> ##2
        pins.pulldown_en == 8'h00) else $error("pulldown despite strap");
    a_reset_inputs: assert property ($rose(hresetn) |-> pins.oe == 8'h00)
        else $error("driver on after reset");
    a_reset_pull_on: assert property ($rose(hresetn) && !global_pulldown_disable |-> ##2
        pins.pulldown_en == 8'hff) else $error("pulldowns off after reset");
    cover property (hsel && htrans[1] && hwrite);
    cover property (global_pulldown_disable);
    cover property (pins.oe == 8'hff);
endmodule
bind pbio_port pbio_port_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .global_pulldown_disable(global_pulldown_disable), .pins(pins));

// *** bench/pbio_board.sv ***
// board model: external drivers, pulldowns and floating pins
`timescale 1ns/1ps
module pbio_board (
    // clock
    input  wire logic                 hclk,
    // block side
    input  wire pbio_pkg::pbio_pins_t pins,
    output logic [7:0]                pin_in,
    // external drivers
    input  wire logic [7:0]           ext,
    input  wire logic [7:0]           ext_en
);
    logic [7:0] flt_q = 8'h00;
    // an undriven pin toggles every clock, so stage two and three never agree and the port keeps its old level
    always @(posedge hclk) flt_q <= ~flt_q;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pins.oe[i]) pin_in[i] = pins.out[i];
            else if (ext_en[i]) pin_in[i] = ext[i];
            else if (pins.pulldown_en[i]) pin_in[i] = 1'b0;
            else pin_in[i] = flt_q[i];
        end
    end
endmodule

// *** bench/pbio_port_bench.sv ***
// self-checking bench for the port b i/o block
`timescale 1ns/1ps
module pbio_port_bench;
    import pbio_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hresp, hrdy, strap;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [7:0]  pin_in, ext, ext_en;
    pbio_pins_t  pins;
    pbio_alt_t   alt;
    pbio_fwd_t   fwd;
    int          err_count, comparisons, cyc;
    // address, write data, external level, read, oe, pulldown
    logic [7:0]  tv [5][6] = '{'{8'h14, 8'ha5, 8'h00, 8'ha5, 8'ha5, 8'h5a},
        '{8'h04, 8'h3c, 8'h5a, 8'h7e, 8'ha5, 8'h5a}, '{8'h18, 8'h0f, 8'h5a, 8'h00, 8'ha5, 8'h50},
        '{8'h40, 8'hff, 8'h5a, 8'h00, 8'ha5, 8'h50}, '{8'h14, 8'h00, 8'h5a, 8'h00, 8'h00, 8'hf0}};
    pbio_port DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(hresp), .global_pulldown_disable(strap),
        .port_b_pin_in(pin_in), .pins(pins), .alt(alt), .fwd(fwd));
    pbio_board BRD (.hclk(hclk), .pins(pins), .pin_in(pin_in), .ext(ext), .ext_en(ext_en));
    task automatic ahb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h00_0000, a, 2'b10, w};
        do @(posedge hclk); while (hrdy !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h00_0000, d};
        do @(posedge hclk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst(input logic s);
        hresetn <= 1'b0;
        strap <= s;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
    endtask
    task automatic report_and_stop;
        $display("%0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 1000) begin
            err_count++;
            report_and_stop;
        end
    end
    initial begin
        {hsel, hwrite, haddr, htrans, hwdata, ext, ext_en} = '0;
        alt = '0;
        rst(1'b0);
        chk(pins.pulldown_en, 8'hff);
        foreach (tv[i]) begin
            ext <= tv[i][2];
            ext_en <= 8'hff;
            ahb(tv[i][0], 1'b1, tv[i][1]);
            // pin levels pass a synchroniser before they read back
            repeat (6) @(posedge hclk);
            ahb(tv[i][0], 1'b0, 8'h00);
            chk(rd[7:0], tv[i][3]);
            chk(pins.oe, tv[i][4]);
            chk(pins.pulldown_en, tv[i][5]);
            $display("row %0d done", i);
        end
        rst(1'b0);
        ahb(8'h14, 1'b0, 8'h00);
        chk(rd[7:0], 8'h00);
        ahb(8'h14, 1'b1, 8'hff);
        ahb(8'h04, 1'b0, 8'h00);
        chk(rd[7:0], 8'h3c);
        chk(pins.out, 8'h3c);
        $display("latch across reset done");
        // serial, timer and comparator take over upper pins; levels go forward
        ahb(8'h04, 1'b1, 8'h0c);
        ahb(8'h14, 1'b1, 8'h50);
        alt <= 7'b100_1111;
        repeat (6) @(posedge hclk);
        ahb(8'h04, 1'b0, 8'h00);
        chk(rd[7:0], 8'haa);
        chk(pins.out, 8'hbc);
        chk(pins.oe, 8'hb0);
        chk(pins.pulldown_en, 8'h0f);
        chk({1'b0, fwd}, 8'h57);
        alt <= 7'b010_1111;
        repeat (2) @(posedge hclk);
        chk(pins.out, 8'hac);
        alt <= 7'b011_1111;
        repeat (2) @(posedge hclk);
        chk(pins.out, 8'hbc);
        alt <= '0;
        $display("overrides done");
        rst(1'b1);
        chk(pins.pulldown_en, 8'h00);
        $display("strap done");
        report_and_stop;
    end
endmodule
